// ==== inc/txhc_defines.vh ====
/*
 transmit/hardware configuration register constants: offsets, fields,
 reset values, fifo memory split.
 assumes byte-addressed 32-bit register words on the host bus.
*/
// Operation
// - writing one to tx bit 15 zeroes tx status fifo pointers, self-clears
// - writing one to tx bit 14 zeroes tx data fifo pointers, self-clears
// - overrun-allow zero stalls transmission while status fifo full
// - status-full interrupt is raised regardless of overrun-allow
// - transmitter enable bit one lets queued frame data be sent
// - device clears transmitter enable once stop requested and halted
// - stop request finishes current frame, then stops; bit clears itself
// - host writes to stop bit ignored while it reads one
// - bit 29 selects port/alias fifo byte order, one is big endian
// - bit 28 selects direct-select fifo byte order, one is big endian
// - soft reset clears control registers except endian selects
// - hardware config bit 0 starts soft reset, clears error flags
// - bit 24 read-only, shows sampled auto-crossover strap
// - bits 19:16 set tx allocation in 1KB steps, reset five
// - status fifo takes fixed 512 bytes, rest is tx data fifo
// - receive side gets 16KB minus tx allocation
// - soft reset with phy clocks stopped times out, sets bit 1
`ifndef TXHC_DEFINES_VH
`define TXHC_DEFINES_VH
`define TXHC_TX_CFG_OFS 8'h70
`define TXHC_HARDWARE_CONFIG_OFS 8'h74
`define TXHC_TX_STS_FLUSH_BIT 15
`define TXHC_TX_DAT_FLUSH_BIT 14
`define TXHC_OVR_ALLOW_BIT 2
`define TXHC_TX_ON_BIT 1
`define TXHC_STOP_BIT 0
`define TXHC_PORT_END_BIT 29
`define TXHC_SEL_END_BIT 28
`define TXHC_STRAP_BIT 24
`define TXHC_MBO_BIT 20
`define TXHC_SIZE_LSB 16
`define TXHC_SIZE_MSB 19
`define TXHC_SOFT_RESET_TIMEOUT_BIT 1
`define TXHC_SOFTWARE_RESET_BIT 0
`define TXHC_SIZE_RST 4'h5
`define TXHC_MEM_BYTES 15'h4000
`define TXHC_KB_BYTES 15'h0400
`define TXHC_TX_STS_BYTES 15'h0200
`define TXHC_SOFTWARE_RESET_WAIT_NS 40000
`define TXHC_CLK_NS 40
`define TXHC_STRAP_SETTLE 3'h5
`endif

// ==== src/txhc_sync3.v ====
/*
 three-stage synchroniser for one level from outside the clock domain.
 assumes the level is slow against clk; changes accepted when the last
 two stages agree.
*/
`timescale 1ns/10ps
`default_nettype none
module txhc_sync3 (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // level
    input wire async_in,
    output reg level_q
);
reg s1_q;
reg s2_q;
reg s3_q;
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        level_q <= 1'b0;
    end else if (clk_en) begin
        s1_q <= async_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        // only the later stages are compared; first stage may be metastable
        if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
end
endmodule
`default_nettype wire

// ==== src/txhc_alloc.v ====
/*
 fifo memory split from the tx allocation field.
 assumes field values 2..14; reserved values are passed through unchecked.
*/
`timescale 1ns/10ps
`default_nettype none
`include "txhc_defines.vh"
module txhc_alloc (
    // allocation field
    input wire [3:0] size_kb,
    // byte sizes
    output wire [14:0] tx_data_bytes,
    output wire [14:0] rx_total_bytes
);
wire [14:0] tx_total;
assign tx_total = {1'b0, size_kb, 10'h000};
// status fifo is a fixed slice of the tx allocation
assign tx_data_bytes = tx_total - `TXHC_TX_STS_BYTES;
// memory is 16KB; 15 bits hold 16384 - tx_total since tx_total >= 1
assign rx_total_bytes = `TXHC_MEM_BYTES - tx_total;
endmodule
`default_nettype wire

// ==== src/txhc_regs.v ====
/*
 transmit configuration and hardware configuration registers.
 assumes a single-cycle register strobe from the host bus front end,
 byte address on reg_addr, full 32-bit words; the transmitter reports
 its own halted state, status fifo full and data available.
*/
`timescale 1ns/10ps
`default_nettype none
`include "txhc_defines.vh"
module txhc_regs #(
    parameter SOFTWARE_RESET_WAIT_CYC = (`TXHC_SOFTWARE_RESET_WAIT_NS + `TXHC_CLK_NS - 1) /
        `TXHC_CLK_NS
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // register access
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata_q,
    // transmitter status
    input wire tx_halted,
    input wire tx_sts_full,
    input wire tx_data_avail,
    // phy clocks running and strap pin, asynchronous
    input wire phy_clks_running,
    input wire auto_crossover_strap,
    // transmitter control
    output reg tx_go_q,
    output reg tx_stop_pending_q,
    output reg tx_sts_flush_q,
    output reg tx_data_flush_q,
    output reg tx_sts_full_irq_q,
    // configuration
    output reg port_byte_order_q,
    output reg direct_select_byte_order_q,
    output reg must_be_one_q,
    output reg [3:0] tx_allocation_size_q,
    output reg [14:0] tx_data_bytes_q,
    output reg [14:0] rx_total_bytes_q,
    // soft reset
    output reg software_reset_q,
    output reg error_clear_q,
    output reg soft_reset_timeout_q
);
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WAIT = 3'b010;
localparam [2:0] ST_DONE = 3'b100;
localparam [15:0] WAIT_CYC = SOFTWARE_RESET_WAIT_CYC[15:0];

reg status_overrun_allow_q;
reg tx_enable_q;
reg stop_req_q;
reg strap_q;
reg [2:0] strap_cnt_q;
reg [2:0] software_reset_st_q;
reg [2:0] software_reset_st_d;
reg [15:0] software_reset_cnt_q;
wire strap_lvl;
wire phy_ok;
wire wr_tx;
wire wr_hw;
wire [14:0] tx_data_bytes;
wire [14:0] rx_total_bytes;
wire soft_rst;

function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
        hit = (a == ofs);
    end
endfunction

txhc_sync3 u_strap (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(auto_crossover_strap),
    .level_q(strap_lvl)
);

txhc_sync3 u_phy (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(phy_clks_running),
    .level_q(phy_ok)
);

txhc_alloc u_alloc (
    .size_kb(tx_allocation_size_q),
    .tx_data_bytes(tx_data_bytes),
    .rx_total_bytes(rx_total_bytes)
);

assign wr_tx = reg_wr && hit(reg_addr, `TXHC_TX_CFG_OFS);
assign wr_hw = reg_wr && hit(reg_addr, `TXHC_HARDWARE_CONFIG_OFS);
assign soft_rst = (software_reset_st_q == ST_DONE);

// soft reset sequencer: waits for phy clocks, times out otherwise
always @* begin
    software_reset_st_d = software_reset_st_q;
    case (software_reset_st_q)
        ST_IDLE: begin
            if (wr_hw && reg_wdata[`TXHC_SOFTWARE_RESET_BIT]) begin
                software_reset_st_d = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (phy_ok) begin
                software_reset_st_d = ST_DONE;
            end else if (software_reset_cnt_q >= WAIT_CYC) begin
                software_reset_st_d = ST_IDLE;
            end
        end
        ST_DONE: begin
            software_reset_st_d = ST_IDLE;
        end
        default: begin
            software_reset_st_d = ST_IDLE;
        end
    endcase
end

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        software_reset_st_q <= ST_IDLE;
        software_reset_cnt_q <= 16'h0000;
        software_reset_q <= 1'b0;
        error_clear_q <= 1'b0;
        soft_reset_timeout_q <= 1'b0;
    end else if (clk_en) begin
        software_reset_st_q <= software_reset_st_d;
        if (software_reset_st_q == ST_WAIT) begin
            software_reset_cnt_q <= software_reset_cnt_q + 16'h0001;
        end else begin
            software_reset_cnt_q <= 16'h0000;
        end
        // one-cycle reset pulse, also clears latched tx/rx errors
        software_reset_q <= (software_reset_st_d == ST_DONE);
        error_clear_q <= (software_reset_st_d == ST_DONE);
        if (software_reset_st_q == ST_WAIT && software_reset_st_d == ST_IDLE) begin
            soft_reset_timeout_q <= 1'b1;
        end else if (software_reset_st_d == ST_DONE) begin
            soft_reset_timeout_q <= 1'b0;
        end
    end
end

// strap captured once the synchroniser has settled, then held
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        strap_q <= 1'b0;
        strap_cnt_q <= 3'h0;
    end else if (clk_en) begin
        // synchroniser output is only trusted after four edges
        if (strap_cnt_q != `TXHC_STRAP_SETTLE) begin
            strap_q <= strap_lvl;
            strap_cnt_q <= strap_cnt_q + 3'h1;
        end
    end
end

// transmit configuration
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        status_overrun_allow_q <= 1'b0;
        tx_enable_q <= 1'b0;
        stop_req_q <= 1'b0;
        tx_sts_flush_q <= 1'b0;
        tx_data_flush_q <= 1'b0;
    end else if (clk_en) begin
        // flush strobes self-clear after one cycle
        tx_sts_flush_q <= wr_tx && reg_wdata[`TXHC_TX_STS_FLUSH_BIT];
        tx_data_flush_q <= wr_tx && reg_wdata[`TXHC_TX_DAT_FLUSH_BIT];
        if (soft_rst) begin
            status_overrun_allow_q <= 1'b0;
            tx_enable_q <= 1'b0;
            stop_req_q <= 1'b0;
        end else begin
            if (wr_tx) begin
                status_overrun_allow_q <= reg_wdata[`TXHC_OVR_ALLOW_BIT];
                tx_enable_q <= reg_wdata[`TXHC_TX_ON_BIT];
            end
            // writes land only while the stop bit is low
            if (wr_tx && !stop_req_q) begin
                stop_req_q <= reg_wdata[`TXHC_STOP_BIT];
            end else if (stop_req_q && tx_halted) begin
                stop_req_q <= 1'b0;
                tx_enable_q <= 1'b0;
            end
        end
    end
end

// hardware configuration
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        port_byte_order_q <= 1'b0;
        direct_select_byte_order_q <= 1'b0;
        must_be_one_q <= 1'b0;
        tx_allocation_size_q <= `TXHC_SIZE_RST;
    end else if (clk_en) begin
        if (soft_rst) begin
            // endian selects survive a soft reset
            must_be_one_q <= 1'b0;
            tx_allocation_size_q <= `TXHC_SIZE_RST;
        end else if (wr_hw) begin
            port_byte_order_q <= reg_wdata[`TXHC_PORT_END_BIT];
            direct_select_byte_order_q <= reg_wdata[`TXHC_SEL_END_BIT];
            must_be_one_q <= reg_wdata[`TXHC_MBO_BIT];
            tx_allocation_size_q <=
                reg_wdata[`TXHC_SIZE_MSB:`TXHC_SIZE_LSB];
        end
    end
end

// transmitter drive and registered copies
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        tx_go_q <= 1'b0;
        tx_stop_pending_q <= 1'b0;
        tx_sts_full_irq_q <= 1'b0;
        tx_data_bytes_q <= 15'h0000;
        rx_total_bytes_q <= 15'h0000;
    end else if (clk_en) begin
        // stall on full status fifo unless overrun is allowed
        tx_go_q <= tx_enable_q && tx_data_avail &&
            (status_overrun_allow_q || !tx_sts_full);
        tx_stop_pending_q <= stop_req_q;
        // the full interrupt ignores the overrun-allow setting
        tx_sts_full_irq_q <= tx_sts_full;
        tx_data_bytes_q <= tx_data_bytes;
        rx_total_bytes_q <= rx_total_bytes;
    end
end

// read data; reserved bits are zero
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        reg_rdata_q <= 32'h00000000;
    end else if (clk_en) begin
        reg_rdata_q <= 32'h00000000;
        if (reg_rd && hit(reg_addr, `TXHC_TX_CFG_OFS)) begin
            reg_rdata_q[`TXHC_OVR_ALLOW_BIT] <= status_overrun_allow_q;
            reg_rdata_q[`TXHC_TX_ON_BIT] <= tx_enable_q;
            reg_rdata_q[`TXHC_STOP_BIT] <= stop_req_q;
        end else if (reg_rd && hit(reg_addr, `TXHC_HARDWARE_CONFIG_OFS)) begin
            reg_rdata_q[`TXHC_PORT_END_BIT] <= port_byte_order_q;
            reg_rdata_q[`TXHC_SEL_END_BIT] <= direct_select_byte_order_q;
            reg_rdata_q[`TXHC_STRAP_BIT] <= strap_q;
            reg_rdata_q[`TXHC_MBO_BIT] <= must_be_one_q;
            reg_rdata_q[`TXHC_SIZE_MSB:`TXHC_SIZE_LSB] <=
                tx_allocation_size_q;
            reg_rdata_q[`TXHC_SOFT_RESET_TIMEOUT_BIT] <= soft_reset_timeout_q;
            reg_rdata_q[`TXHC_SOFTWARE_RESET_BIT] <= (software_reset_st_q != ST_IDLE);
        end
    end
end
endmodule
`default_nettype wire

// ==== test/txhc_regs_chk.sv ====
/*
 port checker for txhc_regs.
 assumes clk_en is high whenever the block should make progress.
*/
`timescale 1ns/10ps
`default_nettype none
module txhc_regs_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_q,
    // transmitter side
    input wire logic tx_halted,
    input wire logic tx_sts_full,
    input wire logic tx_stop_pending_q,
    input wire logic tx_sts_flush_q,
    input wire logic tx_data_flush_q,
    input wire logic tx_sts_full_irq_q,
    // configuration and soft reset
    input wire logic [3:0] tx_allocation_size_q,
    input wire logic [14:0] tx_data_bytes_q,
    input wire logic [14:0] rx_total_bytes_q,
    input wire logic software_reset_q,
    input wire logic error_clear_q
);
    // byte sizes lag the size field, so wait two enabled edges after reset
    logic [1:0] up_q;
    wire w70 = clk_en && reg_wr && reg_addr == 8'h70;
    wire r70 = clk_en && reg_rd && reg_addr == 8'h70;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            up_q <= 2'h0;
        else if (clk_en)
            up_q <= {up_q[0], 1'b1};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    property p_sts_flush;
        w70 && reg_wdata[15] |=> s_pulse(tx_sts_flush_q);
    endproperty
    a_sts_flush: assert property (p_sts_flush)
        else $error("status flush pulse wrong");
    property p_dat_flush;
        w70 && reg_wdata[14] |=> s_pulse(tx_data_flush_q);
    endproperty
    a_dat_flush: assert property (p_dat_flush)
        else $error("data flush pulse wrong");
    property p_irq;
        (clk_en && tx_sts_full) [*2] |-> tx_sts_full_irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("full interrupt missing");
    property p_stop;
        clk_en && tx_stop_pending_q && tx_halted |->
            ##[1:2] !tx_stop_pending_q;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop request not cleared");
    property p_software_reset;
        software_reset_q |-> error_clear_q ##1 !software_reset_q;
    endproperty
    a_software_reset: assert property (p_software_reset)
        else $error("soft reset pulse wrong");
    property p_tx_bytes;
        up_q[1] && $stable(tx_allocation_size_q) |-> tx_data_bytes_q ==
            {1'b0, tx_allocation_size_q, 10'h000} - 15'h0200;
    endproperty
    a_tx_bytes: assert property (p_tx_bytes)
        else $error("tx data size wrong");
    property p_rx_bytes;
        up_q[1] && $stable(tx_allocation_size_q) |-> rx_total_bytes_q ==
            15'h4000 - {1'b0, tx_allocation_size_q, 10'h000};
    endproperty
    a_rx_bytes: assert property (p_rx_bytes)
        else $error("rx size wrong");
    property p_rsvd;
        $past(r70) |->
            reg_rdata_q[31:3] == 29'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");
endmodule
bind txhc_regs txhc_regs_chk txhc_regs_chk_i (.clk, .reset_n, .clk_en,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .tx_halted,
    .tx_sts_full, .tx_stop_pending_q, .tx_sts_flush_q, .tx_data_flush_q,
    .tx_sts_full_irq_q, .tx_allocation_size_q, .tx_data_bytes_q,
    .rx_total_bytes_q, .software_reset_q, .error_clear_q);
`default_nettype wire

// ==== test/txhc_tx_model.sv ====
/*
 transmitter model: frames of LEN cycles, a gap, a status fifo of CAP.
 assumes one clock shared with the register block.
*/
`timescale 1ns/10ps
`default_nettype none
module txhc_tx_model #(
    parameter int LEN = 20,
    parameter int CAP = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic tx_go_q,
    input wire logic tx_sts_flush_q,
    input wire logic tx_data_flush_q,
    input wire logic add_frame,
    // state
    output logic tx_halted,
    output logic tx_sts_full,
    output logic tx_data_avail
);
    int run, gap, nq, ns;
    assign tx_halted = run == 0;
    assign tx_sts_full = ns == CAP;
    assign tx_data_avail = nq > 0;
    // the gap hides the one-cycle lag of the registered go level
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run <= 0;
            gap <= 0;
            nq <= 0;
            ns <= 0;
        end else begin
            if (gap > 0)
                gap <= gap - 1;
            if (run == 1)
                gap <= 4;
            if (run > 0)
                run <= run - 1;
            else if (tx_go_q && nq > 0 && gap == 0)
                run <= LEN;
            if (tx_data_flush_q)
                nq <= 0;
            else
                nq <= nq + int'(add_frame) - int'(run == 1);
            if (tx_sts_flush_q)
                ns <= 0;
            else if (run == 1 && ns < CAP)
                ns <= ns + 1;
        end
    end
endmodule
`default_nettype wire

// ==== test/txhc_regs_tb.sv ====
/*
 bench for txhc_regs against a register model and a transmitter model.
 assumes the soft reset wait is shortened to 10 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module txhc_regs_tb;
    logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, srto = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, add_frame = 1'b0;
    logic phy_clks_running = 1'b0, auto_crossover_strap = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_q, m70, m74, rnd;
    logic tx_halted, tx_sts_full, tx_data_avail, tx_go_q, tx_stop_pending_q;
    logic tx_sts_flush_q, tx_data_flush_q, tx_sts_full_irq_q;
    logic port_byte_order_q, direct_select_byte_order_q, must_be_one_q;
    logic software_reset_q, error_clear_q, soft_reset_timeout_q;
    logic [3:0] tx_allocation_size_q;
    logic [14:0] tx_data_bytes_q, rx_total_bytes_q;
    int n_errors = 0, n_checks = 0, seed = 32'h5793, i, k;
    txhc_regs #(.SOFTWARE_RESET_WAIT_CYC(10)) txhc_regs_i (.clk, .reset_n, .clk_en,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .tx_halted,
        .tx_sts_full, .tx_data_avail, .phy_clks_running,
        .auto_crossover_strap, .tx_go_q, .tx_stop_pending_q, .tx_sts_flush_q,
        .tx_data_flush_q, .tx_sts_full_irq_q, .port_byte_order_q,
        .direct_select_byte_order_q, .must_be_one_q, .tx_allocation_size_q,
        .tx_data_bytes_q, .rx_total_bytes_q, .software_reset_q,
        .error_clear_q, .soft_reset_timeout_q);
    txhc_tx_model txhc_tx_model_i (.clk, .reset_n, .tx_go_q, .tx_sts_flush_q,
        .tx_data_flush_q, .add_frame, .tx_halted, .tx_sts_full,
        .tx_data_avail);
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] e74();
        return m74 | {7'h0, auto_crossover_strap, 22'h0, srto, 1'b0};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        if (a == 8'h70)
            m70 = {29'h0, d[2:1], m70[0] | d[0]};
        if (a == 8'h74)
            m74 = d & 32'h301F_0000;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK(reg_rdata_q, e)
    endtask
    // a wait that runs out ends the run as a mismatch
    task automatic wait_for(ref logic s, input logic v);
        for (k = 0; k < 300 && s !== v; k++)
            @(negedge clk);
        if (s !== v) begin
            n_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            stop_test();
        end
    endtask
    task automatic frame();
        add_frame = 1'b1;
        @(negedge clk);
        add_frame = 1'b0;
        @(negedge clk);
    endtask
    initial begin
        rnd = $random(seed);
        auto_crossover_strap = rnd[0];
        m70 = 32'h0;
        m74 = 32'h0005_0000;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        rd(8'h70, m70);
        rd(8'h74, e74());
        rd(8'h78, 32'h0);
        $display("test reset done");
        for (i = 2; i <= 14; i++) begin
            rnd = $random(seed);
            wr(8'h74, {rnd[31:21], 1'b1, i[3:0], rnd[15:1],
                1'b0});
            rd(8'h74, e74());
            `CHK(must_be_one_q, 1'b1)
            `CHK(port_byte_order_q, rnd[29])
            `CHK(direct_select_byte_order_q, rnd[28])
            `CHK(tx_data_bytes_q, 15'(i * 1024 - 512))
            `CHK(rx_total_bytes_q, 15'(16384 - i * 1024))
        end
        $display("test sizes done");
        repeat (3) frame();
        wr(8'h70, 32'h2);
        wait_for(tx_sts_full, 1'b1);
        repeat (3) @(negedge clk);
        `CHK({tx_go_q, tx_data_avail, tx_sts_full_irq_q}, 3'b011)
        wr(8'h70, 32'h6);
        wait_for(tx_data_avail, 1'b0);
        `CHK(tx_sts_full_irq_q, 1'b1)
        wr(8'h70, 32'h4);
        frame();
        rnd = $random(seed);
        wr(8'h70, {rnd[31:16], 2'b11, rnd[13:3], 3'b100});
        repeat (2) @(negedge clk);
        `CHK({tx_sts_full, tx_data_avail}, 2'b00)
        rd(8'h70, m70);
        $display("test transmit done");
        wr(8'h70, 32'h0);
        frame();
        wr(8'h70, 32'h2);
        wait_for(tx_halted, 1'b0);
        wr(8'h70, 32'h3);
        wr(8'h70, 32'h2);
        rd(8'h70, m70);
        `CHK({tx_halted, tx_stop_pending_q}, 2'b01)
        wait_for(tx_halted, 1'b1);
        repeat (2) @(negedge clk);
        m70 = 32'h0;
        rd(8'h70, m70);
        `CHK(tx_stop_pending_q, 1'b0)
        $display("test stop done");
        wr(8'h70, 32'h4);
        wr(8'h74, m74 | 32'h1);
        wait_for(soft_reset_timeout_q, 1'b1);
        srto = 1'b1;
        rd(8'h74, e74());
        phy_clks_running = 1'b1;
        repeat (6) @(negedge clk);
        wr(8'h74, m74 | 32'h1);
        wait_for(software_reset_q, 1'b1);
        repeat (3) @(negedge clk);
        srto = 1'b0;
        m70 = 32'h0;
        m74 = m74 & 32'h3000_0000 | 32'h0005_0000;
        rd(8'h74, e74());
        rd(8'h70, m70);
        $display("test soft reset done");
        // a write while the clock enable is low must not land
        clk_en = 1'b0;
        wr(8'h70, 32'h6);
        clk_en = 1'b1;
        m70 = 32'h0;
        rd(8'h70, m70);
        $display("test freeze done");
        stop_test();
    end
endmodule
`default_nettype wire
